// *** clk_route_defs.svh ***
// Constants for the status pin clock divider and routing block
// Operation
// - Channel 7 divides by value plus one
// - Divider acts only for synthesizer sources
// - Pin clock from first or second divider
// - Divider input from either pre-divider path
// - Pre-divider code: off, four, five, reserved
// - Pin B selector: clocks, status, disabled
// - Pin A selector uses same four codes
// - First divider fed by selected pre-divider
// - First divider: off, six, else value+1
// - Reference source bypasses channel 7 divider
`ifndef CLK_ROUTE_DEFS_SVH
`define CLK_ROUTE_DEFS_SVH

`define ADDR_CH7_DIV 8'h2C
`define ADDR_ROUTE_CTRL 8'h2D
`define ADDR_CMOS_DIV_A 8'h2E
`define ADDR_AUX_CTRL 8'h30
`define ADDR_CMOS_DIV_B 8'h31
`define ADDR_STATE 8'h32

`define CH7_DIV_RST 8'h05
`define ROUTE_CTRL_RST 8'h0A
`define CMOS_DIV_A_RST 8'h00
`define AUX_CTRL_RST 8'h00
`define CMOS_DIV_B_RST 8'h00

`define PRE_SEL_HI 5
`define PRE_SEL_LO 4
`define PIN_B_SEL_HI 3
`define PIN_B_SEL_LO 2
`define PIN_A_SEL_HI 1
`define PIN_A_SEL_LO 0
`define AUX_CH7_SRC_HI 1
`define AUX_CH7_SRC_LO 0
`define AUX_PRE_PATH 2

`define PRE_RATIO_FOUR 9'h004
`define PRE_RATIO_FIVE 9'h005
`define CMOS_MIN_RATIO 9'h006
`define CMOS_MIN_VALUE 8'h06
`define RATIO_OFF 9'h000
`define DIV_OFF_VALUE 8'h00
`define SYNC_WIDTH 2

`endif

// *** clk_route_pkg.sv ***
// Types for the status pin clock divider and routing block
package clk_route_pkg;

    typedef enum logic [1:0] {
        PIN_SRC_DIV_A,
        PIN_SRC_DIV_B,
        PIN_SRC_STATUS,
        PIN_SRC_OFF
    } pin_src_t;

    typedef enum logic [1:0] {
        PRE_OFF,
        PRE_DIV_FOUR,
        PRE_DIV_FIVE,
        PRE_RESERVED
    } pre_sel_t;

    typedef enum logic [1:0] {
        CH7_SRC_MAIN,
        CH7_SRC_SECOND,
        CH7_SRC_REF_PRI,
        CH7_SRC_REF_SEC
    } ch7_src_t;

endpackage

// *** sync_2ff.sv ***
// Two flip-flop synchroniser for asynchronous level inputs
module sync_2ff #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule // sync_2ff

// *** tick_divider.sv ***
// Tick divider: one output pulse for every ratio input ticks
module tick_divider (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Control
    input wire logic clear_in,
    input wire logic [8:0] ratio_in,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic tick_reg;
    logic enabled;
    logic at_last;

    // A ratio of zero stops the divider and clears the count
    assign enabled = (ratio_in != 9'h000);
    assign at_last = ({1'b0, count_reg} == (ratio_in - 9'h001));
    assign count_next = (clear_in || !enabled) ? 8'h00 :
                        !tick_in ? count_reg :
                        at_last ? 8'h00 : count_reg + 8'h01;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            count_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= enabled && !clear_in && tick_in && at_last;
        end
    end

    assign tick_out = tick_reg;

endmodule // tick_divider

// *** clk_route_top.sv ***
// Channel 7 divider and status pin clock routing with register port
`include "clk_route_defs.svh"

module clk_route_top
    import clk_route_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Source clock ticks
    input wire logic main_synth_tick_in,
    input wire logic second_synth_tick_in,
    input wire logic ref_pri_tick_in,
    input wire logic ref_sec_tick_in,
    // Normal status signals from pins
    input wire logic status_a_in,
    input wire logic status_b_in,
    // Channel 7 clock
    output logic ch7_tick_out,
    // Status pins
    output logic status_pin_a_out,
    output logic status_pin_a_en_out,
    output logic status_pin_b_out,
    output logic status_pin_b_en_out
);

    // Registers
    logic [7:0] ch7_div_reg;
    logic [7:0] route_ctrl_reg;
    logic [7:0] cmos_div_a_reg;
    logic [7:0] aux_ctrl_reg;
    logic [7:0] cmos_div_b_reg;
    logic [7:0] rd_data_reg;
    logic ch7_tick_reg;
    logic pin_a_reg;
    logic pin_a_en_reg;
    logic pin_b_reg;
    logic pin_b_en_reg;

    // Decode
    logic wr_ch7;
    logic wr_route;
    logic wr_div_a;
    logic wr_aux;
    logic wr_div_b;
    logic [7:0] rd_data_next;
    logic [7:0] state_word;

    // Fields
    pre_sel_t cmos_prediv_sel;
    pin_src_t status_pin_a_src_sel;
    pin_src_t status_pin_b_src_sel;
    ch7_src_t ch7_source_sel;
    logic pre_path_second;

    // Datapath
    logic [8:0] ch7_ratio;
    logic [8:0] pre_ratio;
    logic [8:0] div_a_ratio;
    logic [8:0] div_b_ratio;
    logic ch7_from_synth;
    logic ch7_synth_tick;
    logic ch7_div_tick;
    logic ch7_ref_tick;
    logic ch7_tick_next;
    logic pre_main_tick;
    logic pre_second_tick;
    logic pre_tick;
    logic div_a_tick;
    logic div_b_tick;
    logic [1:0] status_sync;
    logic pin_a_next;
    logic pin_b_next;

    assign wr_ch7 = wr_en_in && (addr_in == `ADDR_CH7_DIV);
    assign wr_route = wr_en_in && (addr_in == `ADDR_ROUTE_CTRL);
    assign wr_div_a = wr_en_in && (addr_in == `ADDR_CMOS_DIV_A);
    assign wr_aux = wr_en_in && (addr_in == `ADDR_AUX_CTRL);
    assign wr_div_b = wr_en_in && (addr_in == `ADDR_CMOS_DIV_B);

    assign cmos_prediv_sel =
        pre_sel_t'(route_ctrl_reg[`PRE_SEL_HI:`PRE_SEL_LO]);
    assign status_pin_b_src_sel =
        pin_src_t'(route_ctrl_reg[`PIN_B_SEL_HI:`PIN_B_SEL_LO]);
    assign status_pin_a_src_sel =
        pin_src_t'(route_ctrl_reg[`PIN_A_SEL_HI:`PIN_A_SEL_LO]);
    assign ch7_source_sel =
        ch7_src_t'(aux_ctrl_reg[`AUX_CH7_SRC_HI:`AUX_CH7_SRC_LO]);
    assign pre_path_second = aux_ctrl_reg[`AUX_PRE_PATH];

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ch7_div_reg <= `CH7_DIV_RST;
            route_ctrl_reg <= `ROUTE_CTRL_RST;
            cmos_div_a_reg <= `CMOS_DIV_A_RST;
            aux_ctrl_reg <= `AUX_CTRL_RST;
            cmos_div_b_reg <= `CMOS_DIV_B_RST;
        end else begin
            if (wr_ch7) ch7_div_reg <= wr_data_in;
            if (wr_route) route_ctrl_reg <= wr_data_in;
            if (wr_div_a) cmos_div_a_reg <= wr_data_in;
            if (wr_aux) aux_ctrl_reg <= wr_data_in;
            if (wr_div_b) cmos_div_b_reg <= wr_data_in;
        end
    end

    // Read side: state word shows live routing, unmapped reads give zero
    assign state_word = {4'h0, ch7_from_synth, pre_ratio != `RATIO_OFF,
                         pin_b_reg, pin_a_reg};
    assign rd_data_next = !rd_en_in ? 8'h00 :
        (addr_in == `ADDR_CH7_DIV) ? ch7_div_reg :
        (addr_in == `ADDR_ROUTE_CTRL) ? route_ctrl_reg :
        (addr_in == `ADDR_CMOS_DIV_A) ? cmos_div_a_reg :
        (addr_in == `ADDR_AUX_CTRL) ? aux_ctrl_reg :
        (addr_in == `ADDR_CMOS_DIV_B) ? cmos_div_b_reg :
        (addr_in == `ADDR_STATE) ? state_word : 8'h00;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Channel 7 path
    assign ch7_ratio = {1'b0, ch7_div_reg} + 9'h001;
    assign ch7_from_synth = (ch7_source_sel == CH7_SRC_MAIN) ||
                            (ch7_source_sel == CH7_SRC_SECOND);
    assign ch7_synth_tick = (ch7_source_sel == CH7_SRC_SECOND) ?
                            second_synth_tick_in : main_synth_tick_in;
    assign ch7_ref_tick = (ch7_source_sel == CH7_SRC_REF_SEC) ?
                          ref_sec_tick_in : ref_pri_tick_in;
    // A reference source skips the divider entirely
    assign ch7_tick_next = ch7_from_synth ? ch7_div_tick :
                           ch7_ref_tick;

    tick_divider u_ch7_div (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(wr_ch7 || wr_aux || !ch7_from_synth),
        .ratio_in(ch7_ratio),
        .tick_in(ch7_synth_tick),
        .tick_out(ch7_div_tick)
    );

    // Pre-divider ratio; the reserved code stops the clock like disabled
    assign pre_ratio = (cmos_prediv_sel == PRE_DIV_FOUR) ? `PRE_RATIO_FOUR :
                       (cmos_prediv_sel == PRE_DIV_FIVE) ? `PRE_RATIO_FIVE :
                       `RATIO_OFF;

    tick_divider u_pre_main (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(wr_route),
        .ratio_in(pre_ratio),
        .tick_in(main_synth_tick_in),
        .tick_out(pre_main_tick)
    );

    tick_divider u_pre_second (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(wr_route),
        .ratio_in(pre_ratio),
        .tick_in(second_synth_tick_in),
        .tick_out(pre_second_tick)
    );

    assign pre_tick = pre_path_second ? pre_second_tick :
                      pre_main_tick;

    // Small settings are clamped to six to keep the CMOS output in range
    function automatic logic [8:0] cmos_ratio(input logic [7:0] value);
        if (value == `DIV_OFF_VALUE) begin
            cmos_ratio = `RATIO_OFF;
        end else if (value < `CMOS_MIN_VALUE) begin
            cmos_ratio = `CMOS_MIN_RATIO;
        end else begin
            cmos_ratio = {1'b0, value} + 9'h001;
        end
    endfunction

    assign div_a_ratio = cmos_ratio(cmos_div_a_reg);
    assign div_b_ratio = cmos_ratio(cmos_div_b_reg);

    tick_divider u_cmos_div_a (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(wr_div_a),
        .ratio_in(div_a_ratio),
        .tick_in(pre_tick),
        .tick_out(div_a_tick)
    );

    tick_divider u_cmos_div_b (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(wr_div_b),
        .ratio_in(div_b_ratio),
        .tick_in(pre_tick),
        .tick_out(div_b_tick)
    );

    sync_2ff #(
        .WIDTH(`SYNC_WIDTH)
    ) u_status_sync (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .async_in({status_b_in, status_a_in}),
        .sync_out(status_sync)
    );

    // Pin multiplexers
    function automatic logic pin_mux(input pin_src_t sel,
                                     input logic a_tick,
                                     input logic b_tick,
                                     input logic status);
        case (sel)
            PIN_SRC_DIV_A: pin_mux = a_tick;
            PIN_SRC_DIV_B: pin_mux = b_tick;
            PIN_SRC_STATUS: pin_mux = status;
            default: pin_mux = 1'b0;
        endcase
    endfunction

    assign pin_a_next = pin_mux(status_pin_a_src_sel, div_a_tick,
                                div_b_tick, status_sync[0]);
    assign pin_b_next = pin_mux(status_pin_b_src_sel, div_a_tick,
                                div_b_tick, status_sync[1]);

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ch7_tick_reg <= 1'b0;
            pin_a_reg <= 1'b0;
            pin_a_en_reg <= 1'b0;
            pin_b_reg <= 1'b0;
            pin_b_en_reg <= 1'b0;
        end else begin
            ch7_tick_reg <= ch7_tick_next;
            pin_a_reg <= pin_a_next;
            pin_a_en_reg <= (status_pin_a_src_sel != PIN_SRC_OFF);
            pin_b_reg <= pin_b_next;
            pin_b_en_reg <= (status_pin_b_src_sel != PIN_SRC_OFF);
        end
    end

    assign rd_data_out = rd_data_reg;
    assign ch7_tick_out = ch7_tick_reg;
    assign status_pin_a_out = pin_a_reg;
    assign status_pin_a_en_out = pin_a_en_reg;
    assign status_pin_b_out = pin_b_reg;
    assign status_pin_b_en_out = pin_b_en_reg;

    // Helpers: channel 7 synth ticks and divider A pre-divider ticks seen since the last divided tick
    logic [9:0] ch7_span_reg;
    logic [9:0] div_a_span_reg;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ch7_span_reg <= 10'h000;
            div_a_span_reg <= 10'h000;
        end else begin
            // A clearing write drops a tick of its own cycle, as the
            // divider does; route changes leave divider A counting
            if (wr_ch7 || wr_aux || !ch7_from_synth) begin
                ch7_span_reg <= 10'h000;
            end else if (ch7_div_tick) begin
                ch7_span_reg <= {9'h000, ch7_synth_tick};
            end else if (ch7_synth_tick) begin
                ch7_span_reg <= ch7_span_reg + 10'h001;
            end
            if (wr_div_a) begin
                div_a_span_reg <= 10'h000;
            end else if (div_a_tick) begin
                div_a_span_reg <= {9'h000, pre_tick};
            end else if (pre_tick) begin
                div_a_span_reg <= div_a_span_reg + 10'h001;
            end
        end
    end

    sequence s_ch7_ref_tick;
        !ch7_from_synth && ch7_ref_tick;
    endsequence

    sequence s_ch7_out_pulse;
        ##1 ch7_tick_out;
    endsequence

    a_ch7_reset_val: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        $fell(reset_in) |-> (ch7_div_reg == `CH7_DIV_RST))
        else $error("channel 7 divider value not at reset value");

    a_ch7_ratio: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        ch7_div_tick && $past(ch7_from_synth) && !$past(wr_ch7) |->
        (ch7_span_reg == {1'b0, ch7_ratio}))
        else $error("channel 7 divided by wrong ratio");

    a_ch7_ref_bypass: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        s_ch7_ref_tick |-> s_ch7_out_pulse)
        else $error("reference tick did not bypass divider");

    a_ch7_ref_nodiv: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        !ch7_from_synth |=> !ch7_div_tick)
        else $error("channel 7 divider ran on a reference source");

    a_prediv_off: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        ((cmos_prediv_sel == PRE_OFF) || (cmos_prediv_sel == PRE_RESERVED))
        |=> !pre_main_tick && !pre_second_tick)
        else $error("pre-divider ticked while disabled");

    a_prediv_path: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        pre_tick && !pre_path_second |->
        $past(main_synth_tick_in))
        else $error("pre-divider tick without main synth tick");

    a_div_a_off: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (cmos_div_a_reg == `DIV_OFF_VALUE) |=> !div_a_tick)
        else $error("first CMOS divider ticked while disabled");

    a_div_a_ratio: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        div_a_tick && !$past(wr_div_a) && !$past(wr_route) &&
        !$past(wr_aux) |->
        (div_a_span_reg == {1'b0, div_a_ratio}))
        else $error("first CMOS divider used wrong ratio");

    a_pin_a_status: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (status_pin_a_src_sel == PIN_SRC_STATUS) |=>
        (status_pin_a_out == $past(status_sync[0])))
        else $error("pin A does not follow status signal");

    a_pin_b_off: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (status_pin_b_src_sel == PIN_SRC_OFF) |=>
        !status_pin_b_out && !status_pin_b_en_out)
        else $error("pin B not disabled");

    a_pin_clock_src: assert property (
        @(posedge clk_sys_in) disable iff (reset_in)
        (status_pin_a_src_sel == PIN_SRC_DIV_B) && div_b_tick |=>
        status_pin_a_out)
        else $error("pin A missed second divider clock");

endmodule // clk_route_top

// *** status_pin_clock_divider_mux_test.sv ***
// Self-checking testbench for the channel 7 and status pin clock router
`include "clk_route_defs.svh"

module status_pin_clock_divider_mux_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_in, reset_in;
    logic [7:0] addr_in, wr_data_in, rd_data_out;
    logic wr_en_in, rd_en_in;
    logic main_synth_tick_in, second_synth_tick_in;
    logic ref_pri_tick_in, ref_sec_tick_in;
    logic status_a_in, status_b_in, ch7_tick_out;
    logic status_pin_a_out, status_pin_a_en_out;
    logic status_pin_b_out, status_pin_b_en_out;
    int failures, checked, p, n;
    int main_per, second_per, ref_pri_per, ref_sec_per, cyc;
    int ch7_exp[4] = '{5, 10, 3, 4};
    logic [7:0] ch7_val[2] = '{8'h00, 8'hFF};
    int ch7_ratio[2] = '{1, 256};
    logic [1:0] pre_c[5] = '{2'd1, 2'd2, 2'd1, 2'd2, 2'd1};
    logic [7:0] dv[5] = '{8'h03, 8'h06, 8'h01, 8'h07, 8'hFF};
    logic path[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int pin_exp[5] = '{24, 35, 48, 40, 1024};
    logic [1:0] off_pre[3] = '{2'd0, 2'd3, 2'd1};
    logic [7:0] off_dv[3] = '{8'h06, 8'h06, 8'h00};

    clk_route_top u_dut (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out),
        .main_synth_tick_in(main_synth_tick_in),
        .second_synth_tick_in(second_synth_tick_in),
        .ref_pri_tick_in(ref_pri_tick_in),
        .ref_sec_tick_in(ref_sec_tick_in),
        .status_a_in(status_a_in),
        .status_b_in(status_b_in),
        .ch7_tick_out(ch7_tick_out),
        .status_pin_a_out(status_pin_a_out),
        .status_pin_a_en_out(status_pin_a_en_out),
        .status_pin_b_out(status_pin_b_out),
        .status_pin_b_en_out(status_pin_b_en_out)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // Source clocks as tick trains; a period of 0 keeps a source silent
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        main_synth_tick_in <= (main_per != 0) && (cyc % main_per == 0);
        second_synth_tick_in <= (second_per != 0) && (cyc % second_per == 0);
        ref_pri_tick_in <= (ref_pri_per != 0) && (cyc % ref_pri_per == 0);
        ref_sec_tick_in <= (ref_sec_per != 0) && (cyc % ref_sec_per == 0);
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_en_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rd_data_out;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check(name, d, exp);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return ch7_tick_out;
            1: return status_pin_a_out;
            default: return status_pin_b_out;
        endcase
    endfunction

    // The first interval after a write may be short, so the third pulse
    // is timed against the second; -1 means the bound ran out
    task automatic measure(input int s, output int per);
        int hits;
        int last;
        hits = 0;
        last = 0;
        per = -1;
        for (int t = 0; t < 3500 && hits < 3; t++) begin
            @(negedge clk_sys_in);
            if (pick(s) === 1'b1) begin
                hits++;
                if (hits == 3) begin
                    per = t - last;
                end
                last = t;
            end
        end
    endtask

    task automatic count_pulses(input int s, output int cnt);
        cnt = 0;
        for (int t = 0; t < 600; t++) begin
            @(negedge clk_sys_in);
            if (pick(s) === 1'b1) begin
                cnt++;
            end
        end
    endtask

    initial begin
        reset_in = 1'b1;
        addr_in = 8'h00;
        wr_data_in = 8'h00;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        {main_synth_tick_in, second_synth_tick_in} = 2'b00;
        {ref_pri_tick_in, ref_sec_tick_in} = 2'b00;
        {status_a_in, status_b_in} = 2'b00;
        {main_per, second_per, ref_pri_per, ref_sec_per, cyc} = '0;
        failures = 0;
        checked = 0;
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rd_chk("ch7_divider_value", `ADDR_CH7_DIV, 8'h05);
        rd_chk("route_ctrl", `ADDR_ROUTE_CTRL, 8'h0A);
        rd_chk("cmos_div_a_value", `ADDR_CMOS_DIV_A, 8'h00);
        reg_wr(8'h40, 8'hFF);
        rd_chk("unmapped", 8'h40, 8'h00);
        @(posedge clk_sys_in);
        status_a_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("pin_a_en", status_pin_a_en_out, 1'b1);
        check("pin_a_status", status_pin_a_out, 1'b1);
        check("pin_b_en", status_pin_b_en_out, 1'b1);
        check("pin_b_status", status_pin_b_out, 1'b0);
        @(posedge clk_sys_in);
        status_b_in <= 1'b1;
        status_a_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("pin_a_status", status_pin_a_out, 1'b0);
        check("pin_b_status", status_pin_b_out, 1'b1);
        // Read-write fields, with the spare bits of the route control
        reg_wr(`ADDR_CH7_DIV, 8'hA5);
        reg_wr(`ADDR_ROUTE_CTRL, 8'hA5);
        reg_wr(`ADDR_CMOS_DIV_A, 8'hA5);
        rd_chk("ch7_divider_value", `ADDR_CH7_DIV, 8'hA5);
        rd_chk("route_ctrl", `ADDR_ROUTE_CTRL, 8'hA5);
        rd_chk("cmos_div_a_value", `ADDR_CMOS_DIV_A, 8'hA5);
        // Both pins follow the idle divider B; pre-divider on, main source
        rd_chk("state_reg", `ADDR_STATE, 8'h0C);
        reg_wr(`ADDR_STATE, 8'hF3);
        rd_chk("state_reg", `ADDR_STATE, 8'h0C);
        // Channel 7 through every source code
        main_per = 1;
        second_per = 2;
        ref_pri_per = 3;
        ref_sec_per = 4;
        reg_wr(`ADDR_CH7_DIV, 8'h04);
        for (int c = 0; c < 4; c++) begin
            reg_wr(`ADDR_AUX_CTRL, 8'(c));
            measure(0, p);
            check("ch7_period", p, ch7_exp[c]);
        end
        reg_wr(`ADDR_AUX_CTRL, 8'h00);
        for (int i = 0; i < 2; i++) begin
            reg_wr(`ADDR_CH7_DIV, ch7_val[i]);
            measure(0, p);
            check("ch7_period", p, ch7_ratio[i]);
        end
        // Pin A from divider A behind each pre-divider and path
        for (int i = 0; i < 5; i++) begin
            reg_wr(`ADDR_CMOS_DIV_A, dv[i]);
            reg_wr(`ADDR_AUX_CTRL, {5'b00000, path[i], 2'b00});
            reg_wr(`ADDR_ROUTE_CTRL, {2'b00, pre_c[i], 2'b11, 2'b00});
            measure(1, p);
            check("pin_a_period", p, pin_exp[i]);
        end
        check("pin_b_off_en", status_pin_b_en_out, 1'b0);
        check("pin_b_off", status_pin_b_out, 1'b0);
        for (int i = 0; i < 3; i++) begin
            reg_wr(`ADDR_CMOS_DIV_A, off_dv[i]);
            reg_wr(`ADDR_ROUTE_CTRL, {2'b00, off_pre[i], 2'b11, 2'b00});
            count_pulses(1, n);
            check("pin_a_silent", n, 0);
        end
        // Divider B against divider A on both pins
        reg_wr(`ADDR_CMOS_DIV_A, 8'h03);
        reg_wr(`ADDR_CMOS_DIV_B, 8'h07);
        reg_wr(`ADDR_ROUTE_CTRL, 8'h14);
        measure(1, p);
        check("pin_a_period", p, 24);
        measure(2, p);
        check("pin_b_period", p, 32);
        reg_wr(`ADDR_ROUTE_CTRL, 8'h11);
        measure(1, p);
        check("pin_a_period", p, 32);
        measure(2, p);
        check("pin_b_period", p, 24);
        reg_wr(`ADDR_ROUTE_CTRL, 8'h1B);
        count_pulses(1, n);
        check("pin_a_off", n, 0);
        check("pin_a_en", status_pin_a_en_out, 1'b0);
        test_done();
    end
endmodule // status_pin_clock_divider_mux_test
